// >>> acts_analog_src.sv
`timescale 1ns/1ps
module acts_analog_src
  import acts_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          sample_en,
  input  wire logic                          analog_off,
  input  wire logic [acts_pkg::RES_BITS-1:0] dac_code,
  input  wire logic [acts_pkg::RES_BITS-1:0] pin_code,
  input  wire logic                          pin_below,
  input  wire logic                          pin_above,
  output logic                               cmp_above_async,
  output logic                               below_ground_async,
  output logic                               above_ref_async
);
  logic [RES_BITS-1:0] cap_q = '0;
  logic                lo_q  = 1'b0;
  logic                hi_q  = 1'b0;
  // Capacitor follows the pin only while the switch is closed
  always @(posedge clk) begin
    if (sample_en) begin
      cap_q <= pin_code;
      lo_q  <= pin_below;
      hi_q  <= pin_above;
    end
  end
  // Held level sits half a step above its code, so a trial never ties
  assign cmp_above_async    = !analog_off && ({cap_q, 1'b1} > {dac_code, 1'b0});
  assign below_ground_async = lo_q;
  assign above_ref_async    = hi_q;
endmodule : acts_analog_src

// >>> acts_pkg.sv
package acts_pkg;

  // ***************************************************************
  // Converter geometry
  // ***************************************************************
  localparam int unsigned RES_BITS    = 10;            // Result width
  localparam int unsigned CNT_W       = 11;            // Phase counter width
  localparam int unsigned TCL_PER_CLK = 2;             // One CPU period is two units
  localparam int unsigned CLK_MHZ     = 200;           // Clock rate of this block
  localparam logic [9:0]  CODE_MIN    = 10'h000;       // Code below ground reference
  localparam logic [9:0]  CODE_MAX    = 10'h3ff;       // Code above analogue reference
  localparam logic [9:0]  CODE_RST    = 10'h000;       // Result after reset

  // ***************************************************************
  // Select encodings
  // ***************************************************************
  localparam logic [1:0] CC_FAST = 2'b00;
  localparam logic [1:0] CC_RSVD = 2'b01;
  localparam logic [1:0] CC_SLOW = 2'b10;
  localparam logic [1:0] CC_MID  = 2'b11;

  // ***************************************************************
  // Phase lengths in half-CPU-period units, indexed by sample select
  // ***************************************************************
  localparam int unsigned SMP_TCL_FAST [0:3] = '{120, 140, 200, 400};
  localparam int unsigned CMP_TCL_FAST [0:3] = '{240, 280, 280, 280};
  localparam int unsigned EXT_TCL_FAST [0:3] = '{28, 16, 52, 44};
  localparam int unsigned SMP_TCL_MID  [0:3] = '{240, 280, 400, 800};
  localparam int unsigned CMP_TCL_MID  [0:3] = '{480, 560, 560, 560};
  localparam int unsigned EXT_TCL_MID  [0:3] = '{52, 28, 100, 52};
  localparam int unsigned SMP_TCL_SLOW [0:3] = '{480, 560, 800, 1600};
  localparam int unsigned CMP_TCL_SLOW [0:3] = '{960, 1120, 1120, 1120};
  localparam int unsigned EXT_TCL_SLOW [0:3] = '{100, 52, 196, 164};

  // Convert a length in units to clock cycles, never below one
  function automatic logic [CNT_W-1:0] tcl_to_cyc(input int unsigned half_cpu_period_unit);
    int unsigned c;
    c = half_cpu_period_unit / TCL_PER_CLK;
    if (c == 0) begin
      c = 1;
    end
    return CNT_W'(c);
  endfunction : tcl_to_cyc

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_SAMPLE  = 4'b0010,
    ST_COMPARE = 4'b0100,
    ST_EXTRA   = 4'b1000
  } acts_state_t;

endpackage : acts_pkg

// >>> acts_sequencer.sv
// Functional notes
// - Timing comes from two 2-bit select fields
// - Lengths counted in half CPU periods
// - Fast select gives 388 to 724 units
// - Middle select gives 772 to 1412 units
// - Slow select gives 1540 to 2884 units
// - Sample first, then ten comparison steps
// - Total is sample plus compare plus extra
// - Input changes after sampling are ignored
// - Out-of-range inputs saturate to 000 or 3ff
// - Ten-bit code, step is reference over 1024
// - Power-off bit switches converter circuitry off
`timescale 1ns/1ps
module acts_sequencer (
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic                      start,
  input  wire logic [1:0]                conv_clock_select,
  input  wire logic [1:0]                sample_clock_select,
  input  wire logic                      converter_power_off,
  input  wire logic                      cmp_above_async,
  input  wire logic                      below_ground_async,
  input  wire logic                      above_ref_async,
  output logic                           sample_en,
  output logic [acts_pkg::RES_BITS-1:0]  dac_code,
  output logic [acts_pkg::RES_BITS-1:0]  result,
  output logic                           done,
  output logic                           busy,
  output logic                           analog_off,
  output logic                           select_reserved
);
  import acts_pkg::*;

  // ***************************************************************
  // Internal state
  // ***************************************************************
  acts_timing_if tif ();

  acts_state_t            state_q;
  logic [CNT_W-1:0]       cnt_q;
  logic [3:0]             bit_q;
  logic [RES_BITS-1:0]    sar_q;
  logic [1:0]             cc_sel_q;
  logic [1:0]             sc_sel_q;
  logic                   low_sat_q;
  logic                   high_sat_q;
  logic [2:0]             sync1_q;
  logic [2:0]             sync2_q;
  logic                   last_cyc;
  logic                   go;

  acts_timing u_timing (
    .tif (tif.lookup)
  );

  // Live selects feed the lookup while idle so the start edge loads the
  // sample length at once; frozen copies serve the rest of the conversion
  assign tif.cc_sel = (state_q == ST_IDLE) ? conv_clock_select : cc_sel_q;
  assign tif.sc_sel = (state_q == ST_IDLE) ? sample_clock_select : sc_sel_q;

  assign last_cyc = (cnt_q == '0);
  // A reserved select or power-off refuses the start request
  assign go = start && !converter_power_off && (conv_clock_select != CC_RSVD);

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  // Comparator and range flags come from the analogue side
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {above_ref_async, below_ground_async, cmp_above_async};
      sync2_q <= sync1_q;
    end
  end

  // ***************************************************************
  // Select capture
  // ***************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cc_sel_q <= CC_FAST;
      sc_sel_q <= 2'h0;
    end else if (state_q == ST_IDLE && go) begin
      cc_sel_q <= conv_clock_select;
      sc_sel_q <= sample_clock_select;
    end
  end

  // ***************************************************************
  // Phase sequencer
  // ***************************************************************
  // One counter serves every phase; it loads length minus one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      bit_q   <= 4'h0;
    end else if (converter_power_off) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      bit_q   <= 4'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (go) begin
            state_q <= ST_SAMPLE;
            cnt_q   <= tif.sample_cyc - CNT_W'(1);
          end
        end
        ST_SAMPLE: begin
          if (last_cyc) begin
            state_q <= ST_COMPARE;
            cnt_q   <= tif.step_cyc - CNT_W'(1);
            bit_q   <= 4'(RES_BITS - 1);
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        ST_COMPARE: begin
          if (last_cyc) begin
            if (bit_q == 4'h0) begin
              state_q <= ST_EXTRA;
              cnt_q   <= tif.extra_cyc - CNT_W'(1);
            end else begin
              bit_q <= bit_q - 4'h1;
              cnt_q <= tif.step_cyc - CNT_W'(1);
            end
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        ST_EXTRA: begin
          if (last_cyc) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // Busy and sample switch
  // ***************************************************************
  // Busy falls with the completion pulse, so a new start is taken right after it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy      <= 1'b0;
      sample_en <= 1'b0;
    end else if (converter_power_off) begin
      busy      <= 1'b0;
      sample_en <= 1'b0;
    end else begin
      busy      <= (state_q == ST_IDLE) ? go : !(state_q == ST_EXTRA && last_cyc);
      if (state_q == ST_IDLE && go) begin
        sample_en <= 1'b1;
      end else if (state_q == ST_SAMPLE && last_cyc && busy) begin
        sample_en <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Saturation capture
  // ***************************************************************
  // Range flags are taken only as sampling ends, later changes are ignored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_sat_q  <= 1'b0;
      high_sat_q <= 1'b0;
    end else if (state_q == ST_SAMPLE && last_cyc && busy) begin
      low_sat_q  <= sync2_q[1];
      high_sat_q <= sync2_q[2];
    end
  end

  // ***************************************************************
  // Successive approximation register
  // ***************************************************************
  // Comparator is read on the last cycle of each step, so the two-flop
  // synchroniser delay fits well inside the shortest step
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sar_q    <= CODE_RST;
      dac_code <= CODE_RST;
    end else if (state_q == ST_SAMPLE && last_cyc && busy) begin
      sar_q    <= CODE_MIN;
      dac_code <= RES_BITS'(1) << (RES_BITS - 1);
    end else if (state_q == ST_COMPARE && last_cyc) begin
      sar_q[bit_q] <= sync2_q[0];
      if (bit_q != 4'h0) begin
        dac_code          <= sar_q | (RES_BITS'(1) << (bit_q - 4'h1));
        dac_code[bit_q]   <= sync2_q[0];
      end else begin
        dac_code[bit_q] <= sync2_q[0];
      end
    end
  end

  // ***************************************************************
  // Result load and completion
  // ***************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result <= CODE_RST;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (state_q == ST_EXTRA && last_cyc && !converter_power_off) begin
        done <= 1'b1;
        if (low_sat_q) begin
          result <= CODE_MIN;
        end else if (high_sat_q) begin
          result <= CODE_MAX;
        end else begin
          result <= sar_q;
        end
      end
    end
  end

  // ***************************************************************
  // Status pins
  // ***************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      analog_off      <= 1'b1;
      select_reserved <= 1'b0;
    end else begin
      analog_off      <= converter_power_off;
      select_reserved <= (conv_clock_select == CC_RSVD);
    end
  end

endmodule : acts_sequencer

// >>> acts_sequencer_monitor.sv
`timescale 1ns/1ps
module acts_sequencer_monitor
  import acts_pkg::*;
(
  input wire logic                       clk,
  input wire logic                       rst_b,
  input wire logic                       start,
  input wire logic [1:0]                 conv_clock_select,
  input wire logic [1:0]                 sample_clock_select,
  input wire logic                       converter_power_off,
  input wire logic                       sample_en,
  input wire logic [acts_pkg::RES_BITS-1:0] dac_code,
  input wire logic [acts_pkg::RES_BITS-1:0] result,
  input wire logic                       done,
  input wire logic                       busy,
  input wire logic                       analog_off,
  input wire logic                       select_reserved
);
  // ****
  // Phase bookkeeping
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [1:0]  cc_q;
  logic [1:0]  sc_q;
  logic [11:0] cnt_q;
  logic [11:0] smp_q;
  logic        acc;
  // Phase length in cycles: 0 sample, 1 one step, 2 extra
  function automatic int ph(input logic [1:0] cc, input logic [1:0] sc, input int k);
    int v;
    case (cc)
      2'b00:   v = k == 0 ? SMP_TCL_FAST[sc] : k == 1 ? CMP_TCL_FAST[sc] / 10 : EXT_TCL_FAST[sc];
      2'b11:   v = k == 0 ? SMP_TCL_MID[sc] : k == 1 ? CMP_TCL_MID[sc] / 10 : EXT_TCL_MID[sc];
      default: v = k == 0 ? SMP_TCL_SLOW[sc] : k == 1 ? CMP_TCL_SLOW[sc] / 10 : EXT_TCL_SLOW[sc];
    endcase
    return v / 2;
  endfunction : ph
  assign acc = start && !busy && !converter_power_off && conv_clock_select != 2'b01;
  // Cycles since the accepted start; wraps harmlessly when idle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      cc_q  <= '0;
      sc_q  <= '0;
    end else if (acc) begin
      cnt_q <= '0;
      cc_q  <= conv_clock_select;
      sc_q  <= sample_clock_select;
    end else begin
      cnt_q <= cnt_q + 12'h001;
    end
  end
  // Length of the current sample window
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) smp_q <= '0;
    else smp_q <= sample_en ? smp_q + 12'h001 : 12'h000;
  end
  property p_start; acc |=> busy && sample_en; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_smp; $fell(sample_en) && busy |-> smp_q == 12'(ph(cc_q, sc_q, 0)); endproperty
  a_smp: assert property (p_smp) else $error("sample length wrong");
  property p_tot;
    done |-> cnt_q == 12'(ph(cc_q, sc_q, 0) + 10 * ph(cc_q, sc_q, 1) + ph(cc_q, sc_q, 2));
  endproperty
  a_tot: assert property (p_tot) else $error("conversion length wrong");
  property p_msb; $fell(sample_en) && busy |-> dac_code == 10'h200; endproperty
  a_msb: assert property (p_msb) else $error("first trial not msb");
  property p_pulse; done |=> !done && !busy; endproperty
  a_pulse: assert property (p_pulse) else $error("done not a pulse");
  property p_res; $changed(result) |-> done; endproperty
  a_res: assert property (p_res) else $error("result moved without done");
  // Busy may only end together with the completion pulse
  property p_hold; busy && !converter_power_off |=> busy ^ done; endproperty
  a_hold: assert property (p_hold) else $error("busy dropped early");
  property p_off;
    converter_power_off ##1 converter_power_off |-> analog_off && !busy && !sample_en && !done;
  endproperty
  a_off: assert property (p_off) else $error("power off not honoured");
  property p_rsv; start && conv_clock_select == 2'b01 && !busy && !done |=> !busy && select_reserved;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved select taken");
endmodule : acts_sequencer_monitor
bind acts_sequencer acts_sequencer_monitor mon_u (.clk, .rst_b, .start, .conv_clock_select,
  .sample_clock_select, .converter_power_off, .sample_en, .dac_code, .result, .done, .busy,
  .analog_off, .select_reserved);

// >>> acts_sequencer_tb.sv
`timescale 1ns/1ps
module acts_sequencer_tb;
  import acts_pkg::*;
  logic clk = 0, rst_b = 0, start = 0, converter_power_off = 0;
  logic [1:0] conv_clock_select = 0, sample_clock_select = 0;
  logic cmp_above_async, below_ground_async, above_ref_async, sample_en, done, busy;
  logic analog_off, select_reserved, pin_below = 0, pin_above = 0;
  logic [9:0] dac_code, result, pin_code = 0, keep;
  logic [1:0] ccs [0:2] = '{2'b00, 2'b11, 2'b10};
  int err_total = 0, cmp_count = 0, seed = 87;
  always #2.5 clk = ~clk;
  acts_sequencer dut_u (.clk, .rst_b, .start, .conv_clock_select, .sample_clock_select,
    .converter_power_off, .cmp_above_async, .below_ground_async, .above_ref_async,
    .sample_en, .dac_code, .result, .done, .busy, .analog_off, .select_reserved);
  acts_analog_src src_u (.clk, .sample_en, .analog_off, .dac_code, .pin_code, .pin_below,
    .pin_above, .cmp_above_async, .below_ground_async, .above_ref_async);
  task chk_code(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_code
  // Completion instant must match the phase sum exactly
  task chk_cnt(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_cnt
  function automatic int tot(input logic [1:0] cc, input logic [1:0] sc);
    int t;
    case (cc)
      2'b00:   t = SMP_TCL_FAST[sc] + CMP_TCL_FAST[sc] + EXT_TCL_FAST[sc];
      2'b11:   t = SMP_TCL_MID[sc] + CMP_TCL_MID[sc] + EXT_TCL_MID[sc];
      default: t = SMP_TCL_SLOW[sc] + CMP_TCL_SLOW[sc] + EXT_TCL_SLOW[sc];
    endcase
    return t / 2;
  endfunction : tot
  // Runs one conversion; chg disturbs the pin and start once sampling is over
  task conv(input logic [1:0] cc, sc, input logic [9:0] code, input logic lo, hi, chg);
    int n;
    conv_clock_select = cc;
    sample_clock_select = sc;
    pin_code = code;
    pin_below = lo;
    pin_above = hi;
    start = 1;
    @(posedge clk) #1;
    start = 0;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge clk) #1;
      n++;
      start = chg && n == 400;
      if (chg && sample_en === 1'b0) pin_code = ~code;
    end
    chk_cnt(n, tot(cc, sc));
    chk_code(result, lo ? 10'h000 : hi ? 10'h3ff : code);
    @(posedge clk) #1;
  endtask : conv
  task print_verdict();
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    #(60000 * 5);
    err_total++;
    print_verdict();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    repeat (8) @(posedge clk);
    #1 rst_b = 1;
    for (int i = 0; i < 12; i++) begin
      conv(ccs[i / 4], 2'(i), i < 4 ? 10'(i * 10'h155) : 10'($random(seed)), 0, 0, 0);
    end
    conv(2'b00, 2'b00, 10'h3ff, 0, 0, 0);
    conv(2'b11, 2'b01, 10'h155, 0, 0, 1);
    conv(2'b00, 2'b10, 10'h2aa, 1, 0, 0);
    conv(2'b00, 2'b11, 10'h001, 0, 1, 0);
    repeat (6) conv(ccs[$unsigned($random(seed)) % 3], 2'($random(seed)), 10'($random(seed)), 0, 0, 0);
    conv_clock_select = 2'b01;
    start = 1;
    @(posedge clk) #1;
    start = 0;
    @(posedge clk) #1;
    chk_code({9'h0, busy}, 10'h000);
    chk_code({9'h0, select_reserved}, 10'h001);
    keep = result;
    conv_clock_select = 2'b11;
    start = 1;
    @(posedge clk) #1;
    start = 0;
    repeat (40) @(posedge clk);
    #1 converter_power_off = 1;
    repeat (30) @(posedge clk);
    #1 chk_code({9'h0, analog_off, busy}, 10'h002);
    chk_code(result, keep);
    converter_power_off = 0;
    repeat (2) @(posedge clk);
    #1 chk_code({9'h0, analog_off}, 10'h000);
    conv(2'b10, 2'b00, 10'h0f0, 0, 0, 0);
    print_verdict();
  end
endmodule : acts_sequencer_tb

// >>> acts_timing.sv
`timescale 1ns/1ps
module acts_timing (
  acts_timing_if.lookup tif
);
  import acts_pkg::*;

  // ***************************************************************
  // Phase length lookup
  // ***************************************************************
  // Comparison length is split evenly over the result bits
  always_comb begin
    tif.reserved   = 1'b0;
    tif.sample_cyc = tcl_to_cyc(SMP_TCL_FAST[tif.sc_sel]);
    tif.step_cyc   = tcl_to_cyc(CMP_TCL_FAST[tif.sc_sel] / RES_BITS);
    tif.extra_cyc  = tcl_to_cyc(EXT_TCL_FAST[tif.sc_sel]);
    case (tif.cc_sel)
      CC_MID: begin
        tif.sample_cyc = tcl_to_cyc(SMP_TCL_MID[tif.sc_sel]);
        tif.step_cyc   = tcl_to_cyc(CMP_TCL_MID[tif.sc_sel] / RES_BITS);
        tif.extra_cyc  = tcl_to_cyc(EXT_TCL_MID[tif.sc_sel]);
      end
      CC_SLOW: begin
        tif.sample_cyc = tcl_to_cyc(SMP_TCL_SLOW[tif.sc_sel]);
        tif.step_cyc   = tcl_to_cyc(CMP_TCL_SLOW[tif.sc_sel] / RES_BITS);
        tif.extra_cyc  = tcl_to_cyc(EXT_TCL_SLOW[tif.sc_sel]);
      end
      CC_RSVD: begin
        tif.reserved = 1'b1;
      end
      default: begin
        tif.reserved = 1'b0;
      end
    endcase
  end

endmodule : acts_timing

// >>> acts_timing_if.sv
`timescale 1ns/1ps
interface acts_timing_if;
  import acts_pkg::*;
  logic [1:0]       cc_sel;
  logic [1:0]       sc_sel;
  logic [CNT_W-1:0] sample_cyc;
  logic [CNT_W-1:0] step_cyc;
  logic [CNT_W-1:0] extra_cyc;
  logic             reserved;

  modport lookup (input cc_sel, input sc_sel,
                  output sample_cyc, output step_cyc, output extra_cyc, output reserved);
  modport user   (output cc_sel, output sc_sel,
                  input sample_cyc, input step_cyc, input extra_cyc, input reserved);
endinterface : acts_timing_if
